/* File: fsps_pkg.sv */
// Purpose: shared constants and types, flash self-program sequencer
// Assumes: apb with 12-bit byte addresses, 32-bit data
// Notes: one word per register
package fsps_pkg;
  // ****************************************************
  // geometry
  // ****************************************************
  localparam int WORD_W = 14;
  localparam int ROW_WORDS = 16;
  localparam int LIDX_W = 4;
  localparam int ADDR_W = 15;
  localparam int CNT_W = 24;
  localparam logic [13:0] BLANK_WORD = 14'h3FFF;
  localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
  localparam logic [7:0] UNLOCK_KEY2 = 8'hAA;
  // ****************************************************
  // register map
  // ****************************************************
  localparam logic [11:0] OFS_ADDR_LO = 12'h000;
  localparam logic [11:0] OFS_ADDR_HI = 12'h004;
  localparam logic [11:0] OFS_DATA_LO = 12'h008;
  localparam logic [11:0] OFS_DATA_HI = 12'h00C;
  localparam logic [11:0] OFS_CTRL = 12'h010;
  localparam logic [11:0] OFS_UNLOCK = 12'h014;
  localparam int CB_READ = 0;
  localparam int CB_GO = 1;
  localparam int CB_GATE = 2;
  localparam int CB_ERR = 3;
  localparam int CB_ERASE = 4;
  localparam int CB_LATCH = 5;
  localparam int CB_CFG = 6;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  // ****************************************************
  // timing
  // ****************************************************
  localparam int OP_TIME_US = 2000;
  localparam int CLK_MHZ = 100;
  localparam int OP_CYCLES = OP_TIME_US * CLK_MHZ;
  // ****************************************************
  // types
  // ****************************************************
  typedef enum logic [2:0] {
    SQ_IDLE, SQ_RD_WAIT, SQ_RD_ACC, SQ_NOP1, SQ_NOP2, SQ_STALL
  } fsps_seq_e;
  typedef enum logic [1:0] {UL_IDLE, UL_KEY1, UL_ARMED} fsps_unl_e;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } fsps_apb_req_s;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } fsps_apb_rsp_s;
  typedef struct packed {
    logic slot_squash;
    logic core_stall;
  } fsps_core_s;
  typedef struct packed {
    fsps_seq_e seq;
    fsps_unl_e unl;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] data;
    logic rd;
    logic wr;
    logic gate;
    logic err;
    logic erase;
    logic latch_only_load;
    logic config_space_select;
    logic boot;
    logic [CNT_W-1:0] cnt;
    logic [ROW_WORDS-1:0][WORD_W-1:0] latch;
    logic [31:0] prdata;
    logic pslverr;
  } fsps_state_s;
endpackage : fsps_pkg

/* File: fsps_seq.sv */
// Purpose: flash self-program sequencer with apb registers
// Assumes: instr_step pulses once per core instruction slot
// Notes: config space reads return zero, writes to it refused
// How it works
// [RL1] rows of 14-bit words, erase whole row
// [RL2] hidden latches filled only from data pair
// [RL3] sixteen-word row, sixteen latches
// [RL4] core loads address, clears config, sets read
// [RL5] second slot after read is taken
// [RL6] word lands in data pair after access
// [RL7] data pair holds until read or write
// [RL8] software puts two nops after read
// [RL9] erase, load, program need full unlock
// [RL10] unlock is 55h, AAh, go, two nops
// [RL11] go forces next two slots to nop
// [RL12] erase/program stall core about 2 ms
// [RL13] latch load: two nops, no stall
// [RL14] software masks interrupts around unlock
// [RL15] erase: address, select bits, keys, go
// [RL16] erase halts only instruction execution
// [RL17] resume at third instruction after go
// [RL18] program ands latches into unerased row
// [RL19] read/go set only, hardware clears
// [RL20] operations need gate bit, cleared at reset
// [RL21] reset during operation sets error flag
// [RL22] latch-only bit selects load or program
// [RL23] broken pattern resets tracker, no operation
// [RL24] go ignored while gate is clear
//
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/10ps
module fsps_seq
  import fsps_pkg::*;
#(
  parameter int MEM_WORDS = 1024,
  parameter int OP_CYC = OP_CYCLES
) (
  // clock and resets
  input wire logic pclk,
  input wire logic presetn,
  input wire logic por_n,
  // apb slave
  input wire fsps_apb_req_s apb_i,
  output fsps_apb_rsp_s apb_o,
  // core side
  input wire logic instr_step,
  output fsps_core_s core_o
);
  // ****************************************************
  // checks
  // ****************************************************
  localparam int MA_W = $clog2(MEM_WORDS);
  generate
    if (MEM_WORDS < ROW_WORDS || (1 << MA_W) != MEM_WORDS ||
        MA_W > ADDR_W) begin : g_bad_mem
      $error("fsps_seq: bad MEM_WORDS");
    end
    if (OP_CYC < 16 || OP_CYC >= (1 << CNT_W)) begin : g_bad_cyc
      $error("fsps_seq: bad OP_CYC");
    end
  endgenerate
  localparam logic [CNT_W-1:0] OP_LAST = CNT_W'(OP_CYC - 1);

  // ****************************************************
  // decode
  // ****************************************************
  function automatic logic reg_hit(input logic [11:0] a);
    reg_hit = a == OFS_ADDR_LO || a == OFS_ADDR_HI ||
              a == OFS_DATA_LO || a == OFS_DATA_HI ||
              a == OFS_CTRL || a == OFS_UNLOCK;
  endfunction : reg_hit

  fsps_state_s st_ff;
  fsps_state_s nxt_st;
  logic [WORD_W-1:0] mem [MEM_WORDS];
  logic op_live_ff;
  logic nxt_op_live;
  logic mem_erase;
  logic mem_prog;
  logic rd_done;
  logic data_wr;
  logic wr_acc;
  logic [MA_W-1:0] midx;
  logic [MA_W-LIDX_W-1:0] row;
  logic [LIDX_W-1:0] lidx;
  logic [WORD_W-1:0] mem_rd;
  logic [7:0] ctl_rd;

  assign midx = st_ff.addr[MA_W-1:0];
  assign row = midx[MA_W-1:LIDX_W];
  assign lidx = midx[LIDX_W-1:0];
  assign mem_rd = mem[midx];
  assign wr_acc = apb_i.psel && apb_i.penable && apb_i.pwrite;
  assign ctl_rd = {1'b0, st_ff.config_space_select, st_ff.latch_only_load, st_ff.erase,
                   st_ff.err, st_ff.gate, st_ff.wr, st_ff.rd};

  // ****************************************************
  // next state
  // ****************************************************
  always_comb begin
    nxt_st = st_ff;
    mem_erase = 1'b0;
    mem_prog = 1'b0;
    rd_done = 1'b0;
    data_wr = 1'b0;
    // read data captured in setup so prdata comes from a flop
    if (apb_i.psel && !apb_i.penable) begin
      nxt_st.pslverr = !reg_hit(apb_i.paddr);
      nxt_st.prdata = RST_WORD;
      unique case (apb_i.paddr)
        OFS_ADDR_LO: nxt_st.prdata[7:0] = st_ff.addr[7:0];
        OFS_ADDR_HI: nxt_st.prdata[6:0] = st_ff.addr[14:8];
        OFS_DATA_LO: nxt_st.prdata[7:0] = st_ff.data[7:0];
        OFS_DATA_HI: nxt_st.prdata[5:0] = st_ff.data[13:8];
        OFS_CTRL: nxt_st.prdata[7:0] = ctl_rd;
        default: nxt_st.prdata = RST_WORD;
      endcase
    end
    if (wr_acc) begin
      // any write off the pattern disarms the tracker
      nxt_st.unl = UL_IDLE; // [RL23]
      unique case (apb_i.paddr)
        OFS_ADDR_LO: nxt_st.addr[7:0] = apb_i.pwdata[7:0];
        OFS_ADDR_HI: nxt_st.addr[14:8] = apb_i.pwdata[6:0];
        OFS_DATA_LO: begin
          nxt_st.data[7:0] = apb_i.pwdata[7:0]; // [RL2]
          data_wr = 1'b1;
        end
        OFS_DATA_HI: begin
          nxt_st.data[13:8] = apb_i.pwdata[5:0]; // [RL2]
          data_wr = 1'b1;
        end
        OFS_CTRL: begin
          nxt_st.gate = apb_i.pwdata[CB_GATE];
          nxt_st.erase = apb_i.pwdata[CB_ERASE];
          nxt_st.latch_only_load = apb_i.pwdata[CB_LATCH];
          nxt_st.config_space_select = apb_i.pwdata[CB_CFG];
          if (!apb_i.pwdata[CB_ERR]) begin
            nxt_st.err = 1'b0;
          end
          // zero writes to read/go do nothing
          if (apb_i.pwdata[CB_READ] && st_ff.seq == SQ_IDLE) begin
            nxt_st.rd = 1'b1; // [RL19]
            nxt_st.seq = SQ_RD_WAIT; // [RL4]
          end else if (apb_i.pwdata[CB_GO] && st_ff.seq == SQ_IDLE &&
                       st_ff.unl == UL_ARMED && st_ff.gate &&
                       !st_ff.config_space_select) begin // [RL9] [RL24] [RL20]
            nxt_st.wr = 1'b1; // [RL19]
            nxt_st.seq = SQ_NOP1; // [RL11]
          end
        end
        OFS_UNLOCK: begin
          if (apb_i.pwdata[7:0] == UNLOCK_KEY1) begin // [RL10]
            nxt_st.unl = UL_KEY1;
          end else if (apb_i.pwdata[7:0] == UNLOCK_KEY2 &&
                       st_ff.unl == UL_KEY1) begin // [RL10]
            nxt_st.unl = UL_ARMED;
          end
        end
        default: nxt_st.unl = UL_IDLE;
      endcase
    end
    // slot sequencer; its writes win over software writes
    unique case (st_ff.seq)
      SQ_IDLE: nxt_st.cnt = st_ff.cnt;
      SQ_RD_WAIT: begin
        // first slot after the read still executes
        if (instr_step) begin
          nxt_st.seq = SQ_RD_ACC; // [RL5]
        end
      end
      SQ_RD_ACC: begin
        if (instr_step) begin
          // config space is not modelled, reads back zero
          nxt_st.data = st_ff.config_space_select ? '0 : mem_rd; // [RL6] [RL4]
          nxt_st.rd = 1'b0; // [RL19]
          nxt_st.seq = SQ_IDLE;
          rd_done = 1'b1;
        end
      end
      SQ_NOP1: begin
        if (instr_step) begin
          nxt_st.seq = SQ_NOP2; // [RL11]
        end
      end
      SQ_NOP2: begin
        if (instr_step) begin
          if (st_ff.latch_only_load) begin
            nxt_st.latch[lidx] = st_ff.data; // [RL22] [RL13] [RL2]
            nxt_st.wr = 1'b0; // [RL19]
            nxt_st.seq = SQ_IDLE;
          end else begin
            nxt_st.cnt = '0;
            nxt_st.seq = SQ_STALL; // [RL12]
          end
        end
      end
      SQ_STALL: begin
        if (st_ff.cnt == OP_LAST) begin
          mem_erase = st_ff.erase; // [RL15] [RL1]
          mem_prog = !st_ff.erase; // [RL22]
          for (int i = 0; i < ROW_WORDS; i++) begin
            nxt_st.latch[i] = BLANK_WORD; // [RL2]
          end
          nxt_st.wr = 1'b0; // [RL19]
          nxt_st.seq = SQ_IDLE; // [RL17]
        end else begin
          nxt_st.cnt = st_ff.cnt + 1'b1;
        end
      end
    endcase
    // first cycle after reset: report a lost operation, set wins
    if (!st_ff.boot) begin
      nxt_st.boot = 1'b1;
      if (op_live_ff) begin
        nxt_st.err = 1'b1; // [RL21]
      end
    end
    nxt_op_live = nxt_st.seq == SQ_STALL;
  end

  // ****************************************************
  // registers
  // ****************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0; // [RL20]
      st_ff.seq <= SQ_IDLE;
      st_ff.unl <= UL_IDLE;
      for (int i = 0; i < ROW_WORDS; i++) begin
        st_ff.latch[i] <= BLANK_WORD;
      end
    end else begin
      st_ff <= nxt_st;
    end
  end

  // survives device reset; only power-up resets it, and outside reset and the boot cycle it follows whether the next state is SQ_STALL
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      op_live_ff <= 1'b0;
    end else if (presetn && st_ff.boot) begin
      op_live_ff <= nxt_op_live; // [RL21]
    end
  end

  // ****************************************************
  // flash array
  // ****************************************************
  // programming only clears bits, so words whose latch is blank stay intact
  always_ff @(posedge pclk) begin
    for (int i = 0; i < ROW_WORDS; i++) begin
      if (mem_erase) begin
        mem[{row, LIDX_W'(i)}] <= BLANK_WORD; // [RL1] [RL3]
      end else if (mem_prog) begin
        mem[{row, LIDX_W'(i)}] <=
          mem[{row, LIDX_W'(i)}] & st_ff.latch[i]; // [RL18]
      end
    end
  end

  // ****************************************************
  // outputs
  // ****************************************************
  assign apb_o.prdata = st_ff.prdata;
  assign apb_o.pready = 1'b1;
  assign apb_o.pslverr = apb_i.psel && apb_i.penable && st_ff.pslverr;
  assign core_o.slot_squash = st_ff.seq == SQ_RD_ACC ||
    st_ff.seq == SQ_NOP1 || st_ff.seq == SQ_NOP2; // [RL11] [RL5]
  // clocks keep running; only the core is held
  assign core_o.core_stall = st_ff.seq == SQ_STALL; // [RL16] [RL12]

  // ****************************************************
  // checks on behaviour
  // ****************************************************
  rd_slot_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_ff.seq == SQ_RD_WAIT && instr_step |=>
    core_o.slot_squash && !core_o.core_stall) // [RL5]
    else $error("read slot not taken");

  rd_data_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_ff.seq == SQ_RD_ACC && instr_step && !st_ff.config_space_select |=>
    st_ff.data == $past(mem_rd) && !st_ff.rd) // [RL6]
    else $error("read word not presented");

  rd_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_ff.boot && $changed(st_ff.data) |->
    $past(rd_done) || $past(data_wr)) // [RL7]
    else $error("data pair changed by itself");

  go_nops_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(st_ff.wr) |-> core_o.slot_squash && st_ff.seq == SQ_NOP1)
    // [RL11]
    else $error("go did not force nops");

  stall_run_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_ff.seq == SQ_NOP2 && instr_step && !st_ff.latch_only_load |=>
    core_o.core_stall [*8]) // [RL12]
    else $error("stall too short");

  latch_go_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_ff.seq == SQ_NOP2 && instr_step && st_ff.latch_only_load |=>
    !core_o.core_stall && st_ff.seq == SQ_IDLE &&
    st_ff.latch[$past(lidx)] == $past(st_ff.data)) // [RL13]
    else $error("latch load stalled or lost");

  unlock_need_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(st_ff.wr) |-> $past(st_ff.unl) == UL_ARMED &&
    $past(st_ff.gate)) // [RL9] [RL24]
    else $error("operation without unlock or gate");

  set_only_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_ff.wr && st_ff.seq != SQ_NOP2 && st_ff.seq != SQ_STALL |=>
    st_ff.wr) // [RL19]
    else $error("go bit cleared early");

  blank_after_a: assert property (@(posedge pclk) disable iff (!presetn)
    mem_erase || mem_prog |=> st_ff.latch[0] == BLANK_WORD &&
    st_ff.latch[ROW_WORDS-1] == BLANK_WORD && !core_o.core_stall)
    // [RL2]
    else $error("latches not blanked");

  lost_op_a: assert property (@(posedge pclk) disable iff (!presetn)
    !st_ff.boot && op_live_ff |=> st_ff.err) // [RL21]
    else $error("interrupted operation not flagged");

  bad_key_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_acc && apb_i.paddr == OFS_UNLOCK &&
    apb_i.pwdata[7:0] != UNLOCK_KEY1 &&
    apb_i.pwdata[7:0] != UNLOCK_KEY2 |=> st_ff.unl == UL_IDLE)
    // [RL23]
    else $error("tracker kept after bad key");

endmodule : fsps_seq

/* File: fsps_core_model.sv */
// Purpose: core model issuing instruction slots to the sequencer
// Assumes: one slot pulse every gap cycles; with gap 1 one pulse lands in the first stalled cycle, none after
// Notes: counts squashed slots for the bench
`timescale 1ns/10ps
module fsps_core_model
  import fsps_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pacing and status
  input wire logic [2:0] gap,
  input wire fsps_core_s core_i,
  // slot strobe and count
  output logic instr_step,
  output int nsq
);
  logic [2:0] cnt_ff;
  // ****
  // slot pacing
  // ****
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= '0;
      instr_step <= 1'b0;
      nsq <= 0;
    end else begin
      instr_step <= 1'b0;
      // squashed slots stand for the nops software places
      if (instr_step && core_i.slot_squash) begin
        nsq <= nsq + 1;
      end
      // no interrupts taken, so no sequence is broken
      if (core_i.core_stall) begin
        cnt_ff <= '0;
      end else if (cnt_ff + 3'd1 >= gap) begin
        cnt_ff <= '0;
        instr_step <= 1'b1;
      end else begin
        cnt_ff <= cnt_ff + 3'd1;
      end
    end
  end
endmodule : fsps_core_model

/* File: flash_self_program_sequencer_tb.sv */
// Purpose: self-checking bench for the flash self-program sequencer
// Assumes: short operation time through OP_CYC
// Notes: read results and stall lengths queued by drivers, compared by watchers; slot counts checked inline
`timescale 1ns/10ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin \
  num_errors++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module flash_self_program_sequencer_tb;
  import fsps_pkg::*;
  localparam int OPC = 32;
  logic pclk, presetn, por_n, step;
  logic [2:0] gap;
  fsps_apb_req_s req;
  fsps_apb_rsp_s rsp;
  fsps_core_s core;
  int num_errors, compares, cyc, nsq, scnt, exp_n;
  logic [32:0] got, exp_v;
  logic [13:0] wd;
  logic [32:0] rq[$];
  int sq[$];
  event got_e;
  fsps_seq #(.OP_CYC(OPC)) i_dut (.pclk(pclk), .presetn(presetn),
    .por_n(por_n), .apb_i(req), .apb_o(rsp), .instr_step(step),
    .core_o(core));
  fsps_core_model i_core (.pclk(pclk), .presetn(presetn), .gap(gap),
    .core_i(core), .instr_step(step), .nsq(nsq));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // ****
  // watchers
  // ****
  initial forever begin
    @(got_e);
    // pop once: the macro names its expected value twice
    exp_v = rq.pop_front();
    `CHK(got, exp_v)
  end
  always @(negedge pclk) begin
    if (!presetn) scnt = 0;
    else if (core.core_stall === 1'b1) scnt++;
    else if (scnt != 0) begin
      exp_n = sq.pop_front();
      `CHK(scnt, exp_n)
      scnt = 0;
    end
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      results();
    end
  end
  // ****
  // tasks
  // ****
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [32:0] rr);
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge pclk);
    req.penable <= 1'b1;
    // answer taken at the edge that samples pready high
    do begin
      @(posedge pclk);
    end while (rsp.pready !== 1'b1);
    rr = {rsp.pslverr, rsp.prdata};
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [32:0] x;
    apb(1'b1, a, d, x);
  endtask : wr
  task automatic chk(input logic [11:0] a, input logic [32:0] e);
    logic [32:0] x;
    apb(1'b0, a, 32'h0, x);
    rq.push_back(e);
    got = x;
    ->got_e;
  endtask : chk
  task automatic idle_wait();
    logic [32:0] x;
    // no local limit: the cycle ceiling ends a hang
    do begin
      apb(1'b0, OFS_CTRL, 32'h0, x);
    end while (x[1:0] !== 2'b00);
  endtask : idle_wait
  task automatic setadr(input logic [14:0] a);
    wr(OFS_ADDR_LO, {24'h0, a[7:0]});
    wr(OFS_ADDR_HI, {25'h0, a[14:8]});
  endtask : setadr
  task automatic flash_op(input logic [7:0] ctl, input int e,
                          input logic brk);
    int n0;
    gap <= 3'($urandom_range(1, 4));
    // select bits first; a control write between keys breaks the pattern
    wr(OFS_CTRL, {24'h0, ctl & 8'hFD});
    wr(OFS_UNLOCK, 32'h55);
    wr(OFS_UNLOCK, 32'hAA);
    if (brk) wr(OFS_UNLOCK, 32'h12);
    n0 = nsq;
    wr(OFS_CTRL, {24'h0, ctl});
    idle_wait();
    `CHK(nsq - n0, e)
  endtask : flash_op
  task automatic rdw(input logic [14:0] a, input logic [13:0] e);
    int n0;
    setadr(a);
    n0 = nsq;
    wr(OFS_CTRL, 32'h01);
    idle_wait();
    `CHK(nsq - n0, 1)
    chk(OFS_DATA_LO, {25'h0, e[7:0]});
    chk(OFS_DATA_HI, {27'h0, e[13:8]});
  endtask : rdw
  task automatic results();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results
  // ****
  // main sequence
  // ****
  initial begin
    presetn = 1'b0;
    por_n = 1'b0;
    req = '0;
    gap = 3'd1;
    got = '0;
    void'($urandom(32'h5bcc));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    por_n <= 1'b1;
    for (int a = 0; a <= 20; a += 4) chk(12'(a), 33'h0);
    chk(12'h018, {1'b1, 32'h0});
    wr(OFS_DATA_LO, 32'h5A);
    wr(OFS_DATA_HI, 32'h2A);
    chk(OFS_DATA_LO, 33'h5A);
    chk(OFS_DATA_HI, 33'h2A);
    setadr(15'h0027);
    sq.push_back(OPC);
    flash_op(8'h16, 2, 1'b0);
    rdw(15'h0025, 14'h3FFF);
    wd = 14'($urandom);
    wr(OFS_DATA_LO, {24'h0, wd[7:0]});
    wr(OFS_DATA_HI, {26'h0, wd[13:8]});
    setadr(15'h0025);
    flash_op(8'h26, 2, 1'b0);
    wr(OFS_DATA_LO, 32'hFF);
    wr(OFS_DATA_HI, 32'h3F);
    setadr(15'h002F);
    sq.push_back(OPC);
    flash_op(8'h06, 2, 1'b0);
    rdw(15'h0025, wd);
    rdw(15'h0026, 14'h3FFF);
    setadr(15'h0025);
    flash_op(8'h16, 0, 1'b1);
    flash_op(8'h12, 0, 1'b0);
    flash_op(8'h56, 0, 1'b0);
    rdw(15'h0025, wd);
    // config space is not modelled: a read there gives zero
    wr(OFS_CTRL, 32'h41);
    idle_wait();
    chk(OFS_DATA_LO, 33'h0);
    chk(OFS_DATA_HI, 33'h0);
    setadr(15'h0035);
    wr(OFS_CTRL, 32'h14);
    wr(OFS_UNLOCK, 32'h55);
    wr(OFS_UNLOCK, 32'hAA);
    wr(OFS_CTRL, 32'h16);
    while (core.core_stall !== 1'b1) begin
      @(posedge pclk);
    end
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk(OFS_CTRL, 33'h08);
    wr(OFS_CTRL, 32'h0);
    chk(OFS_CTRL, 33'h0);
    results();
  end
endmodule : flash_self_program_sequencer_tb
